// [hdl/odp_ctrl.sv]
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module odp_ctrl
   import odp_pkg::*;
#(
   parameter logic [CNT_W-1:0] AR_TIME_CYC = CNT_W'(AR_TIME_CYC_DEF),
   parameter logic [CNT_W-1:0] AR_OFF_CYC = CNT_W'(AR_OFF_CYC_DEF)
) (
   input wire logic i_clock, // 125 MHz
   input wire logic i_rst, // Synchronous, active high
   input wire logic [7:0] i_awaddr, // AXI write address
   input wire logic i_awvalid, // AXI
   output logic o_awready, // AXI
   input wire logic [31:0] i_wdata, // AXI write data
   input wire logic [3:0] i_wstrb, // AXI byte strobes
   input wire logic i_wvalid, // AXI
   output logic o_wready, // AXI
   output logic [1:0] o_bresp, // AXI
   output logic o_bvalid, // AXI
   input wire logic i_bready, // AXI
   input wire logic [7:0] i_araddr, // AXI read address
   input wire logic i_arvalid, // AXI
   output logic o_arready, // AXI
   output logic [31:0] o_rdata, // AXI read data
   output logic [1:0] o_rresp, // AXI
   output logic o_rvalid, // AXI
   input wire logic i_rready, // AXI
   input wire logic i_buf_uv, // Buffered supply below threshold
   input wire logic i_vs_uv, // Main supply undervoltage
   input wire logic i_vs_ov, // Main supply overvoltage
   input wire logic i_failsafe, // Fail-safe event
   input wire logic i_gnd_loss, // Signal ground lost
   input wire logic i_pump_low, // Charge pump output low
   input wire logic i_standby, // Device in standby
   input wire logic i_thermal_stage_one, // Thermal stage one threshold
   input wire logic i_thermal_stage_two, // Thermal stage two threshold
   input wire logic i_direct, // Direct drive input pin
   input wire logic [N_CH-1:0] i_overcurrent, // Per-output overcurrent
   input wire logic [N_CH-1:0] i_overtemp, // Per-output cluster overtemperature
   input wire logic [N_CH-1:0] i_low_current, // Per-output current below open-load level
   input wire logic [1:0] i_timer, // Timer 1/2 outputs, same clock
   input wire logic [6:0] i_pwm, // PWM channels 1-7, same clock
   input wire logic [7:0] i_cluster_temp, // Temperature in degrees, same clock
   output logic [N_CH-1:0] o_drive, // Output driver enables
   output logic o_lin_tx_hiz, // LIN transmitter high-Z
   output logic o_can_enable, // CAN stays enabled
   output logic o_pump_enable, // Charge pump enable
   output logic o_gate_pulldown, // Gate drivers resistive low
   output logic o_ec_enable // EC control enable
);
   ////////////////////////////////////////////////////////////////////////////////////////////
   localparam int SYNC_W = 10 + 3 * N_CH;
   logic [SYNC_W-1:0] s1_reg;
   logic [SYNC_W-1:0] s2_reg;
   logic buf_uv_s, vs_uv_s, vs_ov_s, failsafe_s, gnd_loss_s, pump_low_s, standby_s, thermal_stage_one_s, thermal_stage_two_s;
   logic direct_s;
   logic [N_CH-1:0] oc_s, ot_s, lowc_s;

   // Only the second stage is ever read by logic
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
      end else begin
         s1_reg <= {i_buf_uv, i_vs_uv, i_vs_ov, i_failsafe, i_gnd_loss, i_pump_low, i_standby,
                    i_thermal_stage_one, i_thermal_stage_two, i_direct, i_overcurrent, i_overtemp, i_low_current};
         s2_reg <= s1_reg;
      end
   end
   assign {buf_uv_s, vs_uv_s, vs_ov_s, failsafe_s, gnd_loss_s, pump_low_s, standby_s,
           thermal_stage_one_s, thermal_stage_two_s, direct_s, oc_s, ot_s, lowc_s} = s2_reg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   logic awready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg, rdata_next;
   logic rd_hit;
   logic wr_fire, wr_full, rd_fire;
   logic [31:0] w1c;
   logic [31:0] w1c_oc, w1c_ol, w1c_tex;

   assign wr_fire = awready_reg & i_awvalid & i_wvalid;
   assign rd_fire = arready_reg & i_arvalid;
   assign wr_full = &i_wstrb;

   function automatic logic addr_known(input logic [7:0] a);
      return a inside {REG_CTRL, REG_MODE, REG_HB, REG_AR, REG_STATUS, REG_OC, REG_OL, REG_TEX};
   endfunction : addr_known

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         awready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else begin
         awready_reg <= 1'b0;
         if (bvalid_reg && i_bready) begin
            bvalid_reg <= 1'b0;
         end
         if (!bvalid_reg && !awready_reg && i_awvalid && i_wvalid) begin
            awready_reg <= 1'b1;
         end
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= addr_known(i_awaddr) ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= '0;
      end else begin
         arready_reg <= 1'b0;
         if (rvalid_reg && i_rready) begin
            rvalid_reg <= 1'b0;
         end
         if (!rvalid_reg && !arready_reg && i_arvalid) begin
            arready_reg <= 1'b1;
         end
         if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_reg <= rdata_next;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   logic [5:0] ctrl_reg;
   logic [4*N_HS-1:0] mode_reg;
   logic [N_HB:0] hb_reg;
   logic [N_CH-1:0] ar_en_reg, tex_en_reg;

   // Partial-word writes are dropped, so a torn update can never enable an output
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         ctrl_reg <= CTRL_RESET;
         mode_reg <= '0;
         hb_reg <= '0;
         ar_en_reg <= '0;
         tex_en_reg <= '0;
      end else if (wr_fire && wr_full) begin
         if (i_awaddr == REG_CTRL) ctrl_reg <= i_wdata[5:0];
         if (i_awaddr == REG_MODE) mode_reg <= i_wdata[4*N_HS-1:0];
         if (i_awaddr == REG_HB) hb_reg <= i_wdata[N_HB:0];
         if (i_awaddr == REG_AR) begin
            ar_en_reg <= i_wdata[N_CH-1:0] & AR_CAPABLE;
            tex_en_reg <= i_wdata[HI_FIELD+N_CH-1:HI_FIELD];
         end
      end
   end

   // Write-one-to-clear vector for the flag register being addressed
   function automatic logic [31:0] clr_for(input logic [7:0] a);
      return (wr_fire && wr_full && i_awaddr == a) ? i_wdata : 32'h0;
   endfunction : clr_for
   assign w1c = clr_for(REG_STATUS);
   assign w1c_oc = clr_for(REG_OC);
   assign w1c_ol = clr_for(REG_OL);
   assign w1c_tex = clr_for(REG_TEX);

   ////////////////////////////////////////////////////////////////////////////////////////////
   logic buf_uv_flag, vs_uv_flag, vs_ov_flag, pump_low_flag;
   logic [CNT_W-1:0] pl_cnt_reg;
   logic pl_det;
   assign pl_det = (pl_cnt_reg == CNT_W'(PUMP_FILTER_CYC));

   // Set beats clear; unlocked flags drop once the condition has gone
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         buf_uv_flag <= 1'b0;
         vs_uv_flag <= 1'b0;
         vs_ov_flag <= 1'b0;
      end else begin
         buf_uv_flag <= buf_uv_s | (buf_uv_flag & ~w1c[ST_BUF_UV]
                        & ctrl_reg[CTRL_BUF_LOCK]);
         vs_uv_flag <= vs_uv_s | (vs_uv_flag & ~w1c[ST_VS_UV] & ctrl_reg[CTRL_MAIN_LOCK]);
         vs_ov_flag <= vs_ov_s | (vs_ov_flag & ~w1c[ST_VS_OV] & ctrl_reg[CTRL_MAIN_LOCK]);
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         pl_cnt_reg <= '0;
         pump_low_flag <= 1'b0;
      end else begin
         if (!pump_low_s || !o_pump_enable) pl_cnt_reg <= '0;
         else if (!pl_det) pl_cnt_reg <= pl_cnt_reg + 1'b1;
         if (ctrl_reg[CTRL_PUMP_LIVE]) pump_low_flag <= pl_det;
         else pump_low_flag <= pl_det | (pump_low_flag & ~w1c[ST_PUMP_LOW]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   odp_therm_e therm_reg, therm_saved_reg;
   logic standby_d_reg;

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         therm_reg <= TH_NORMAL;
         therm_saved_reg <= TH_NORMAL;
         standby_d_reg <= 1'b0;
      end else begin
         standby_d_reg <= standby_s;
         if (standby_s && !standby_d_reg) begin
            therm_saved_reg <= therm_reg;
         end else if (!standby_s && standby_d_reg) begin
            therm_reg <= (therm_saved_reg == TH_STAGE_TWO) ? TH_STAGE_ONE : therm_saved_reg;
         end else if (!standby_s) begin
            unique case (therm_reg)
               TH_NORMAL: if (thermal_stage_one_s) therm_reg <= TH_STAGE_ONE;
               TH_STAGE_ONE: begin
                  if (thermal_stage_two_s) therm_reg <= TH_STAGE_TWO;
                  else if (!thermal_stage_one_s) therm_reg <= TH_NORMAL;
               end
               TH_STAGE_TWO: if (w1c[ST_THERM] && !thermal_stage_one_s) therm_reg <= TH_NORMAL;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   logic pump_running, main_block, buf_block, common_block;
   logic [N_CH-1:0] req, drv_next, oc_flag, ot_flag, ol_flag, tex_flag, alert_flag;
   logic [4*N_HS-1:0] hs_mode;

   assign pump_running = o_pump_enable & ~pump_low_flag;
   assign main_block = (vs_uv_flag & ctrl_reg[CTRL_UV_SD]) | (vs_ov_flag & ctrl_reg[CTRL_OV_SD]);
   assign buf_block = buf_uv_flag & ctrl_reg[CTRL_BUF_SD];
   assign common_block = failsafe_s | gnd_loss_s | (therm_reg == TH_STAGE_TWO);
   assign hs_mode = mode_reg;

   // Codes outside the table fall to zero, so they never drive
   function automatic logic mode_drive(input logic [3:0] code, input logic [1:0] tmr,
                                       input logic [6:0] pwm, input logic dir);
      logic r;
      r = 1'b0;
      if (code == MODE_ON) r = 1'b1;
      else if (code == MODE_TIMER1) r = tmr[0];
      else if (code == MODE_TIMER2) r = tmr[1];
      else if (code >= MODE_PWM1 && code <= MODE_PWM7) r = pwm[3'(code - MODE_PWM1)];
      else if (code == MODE_DIR) r = dir;
      return r;
   endfunction : mode_drive

   genvar g;
   generate
      for (g = 0; g < N_CH; g++) begin : g_ch
         logic [CNT_W-1:0] off_cnt_reg, ar_cnt_reg, ol_cnt_reg;
         logic [7:0] temp_cap_reg;
         logic cap_valid_reg, is_pwm, chan_ok, oc_hit, ar_on, temp_rise;
         if (g < N_HB) begin : g_hb
            assign req[g] = hb_reg[g];
            assign is_pwm = 1'b0;
         end else begin : g_hs
            assign req[g] = mode_drive(hs_mode[4*(g-N_HB)+:4], i_timer, i_pwm, direct_s);
            assign is_pwm = (hs_mode[4*(g-N_HB)+:4] >= MODE_PWM1)
                            && (hs_mode[4*(g-N_HB)+:4] <= MODE_PWM7);
         end
         if (g == BUF_CH) begin : g_buf
            assign chan_ok = ~buf_block & ~(standby_s & is_pwm);
         end else begin : g_main
            assign chan_ok = pump_running & ~main_block;
         end
         assign ar_on = ar_en_reg[g];
         assign oc_hit = oc_s[g] & o_drive[g];
         assign temp_rise = (i_cluster_temp > temp_cap_reg)
                            && ((i_cluster_temp - temp_cap_reg) > TEMP_RISE_LIMIT);
         assign drv_next[g] = req[g] & chan_ok & ~common_block & ~oc_flag[g] & ~ot_flag[g]
                              & ~tex_flag[g] & (off_cnt_reg == '0);

         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               oc_flag[g] <= 1'b0;
               ot_flag[g] <= 1'b0;
               off_cnt_reg <= '0;
               alert_flag[g] <= 1'b0;
            end else begin
               ot_flag[g] <= ot_s[g] | (ot_flag[g] & ~w1c_oc[HI_FIELD+g]);
               oc_flag[g] <= (oc_hit & ~ar_on) | (oc_flag[g] & ~w1c_oc[g]);
               if (oc_hit && ar_on) off_cnt_reg <= AR_OFF_CYC;
               else if (off_cnt_reg != '0) off_cnt_reg <= off_cnt_reg - 1'b1;
               // Alert holds until the output request drops or auto-restart is disabled for the output
               if (oc_hit && ar_on) alert_flag[g] <= 1'b1;
               else if (!req[g] || !ar_on) alert_flag[g] <= 1'b0;
            end
         end

         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               ar_cnt_reg <= '0;
               cap_valid_reg <= 1'b0;
               temp_cap_reg <= '0;
               tex_flag[g] <= 1'b0;
            end else begin
               if (!alert_flag[g]) begin
                  ar_cnt_reg <= '0;
                  cap_valid_reg <= 1'b0;
               end else if (ar_cnt_reg != AR_TIME_CYC) begin
                  ar_cnt_reg <= ar_cnt_reg + 1'b1;
               end else if (!cap_valid_reg) begin
                  cap_valid_reg <= 1'b1;
                  temp_cap_reg <= i_cluster_temp;
               end
               tex_flag[g] <= (cap_valid_reg & ar_on & tex_en_reg[g] & temp_rise)
                              | (tex_flag[g] & ~w1c_tex[g]);
            end
         end

         // Open load only reports; it never feeds the drive enable
         always_ff @(posedge i_clock) begin
            if (i_rst) begin
               ol_cnt_reg <= '0;
               ol_flag[g] <= 1'b0;
            end else begin
               if (!(o_drive[g] && lowc_s[g])) ol_cnt_reg <= '0;
               else if (ol_cnt_reg != CNT_W'(OL_FILTER_CYC)) ol_cnt_reg <= ol_cnt_reg + 1'b1;
               ol_flag[g] <= (ol_cnt_reg == CNT_W'(OL_FILTER_CYC))
                             | (ol_flag[g] & ~w1c_ol[g]);
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         o_drive <= '0;
         o_lin_tx_hiz <= 1'b0;
         o_can_enable <= 1'b1;
         o_pump_enable <= 1'b0;
         o_gate_pulldown <= 1'b0;
         o_ec_enable <= 1'b0;
      end else begin
         o_drive <= drv_next;
         o_lin_tx_hiz <= buf_uv_s;
         o_can_enable <= 1'b1;
         o_pump_enable <= ~standby_s & (therm_reg != TH_STAGE_TWO) & ~vs_ov_s;
         o_gate_pulldown <= pump_low_flag;
         o_ec_enable <= hb_reg[HB_EC_BIT] & ~pump_low_flag & ~common_block;
      end
   end

   always_comb begin
      rdata_next = 32'h0;
      rd_hit = 1'b1;
      unique case (i_araddr)
         REG_CTRL: rdata_next[5:0] = ctrl_reg;
         REG_MODE: rdata_next[4*N_HS-1:0] = mode_reg;
         REG_HB: rdata_next[N_HB:0] = hb_reg;
         REG_AR: rdata_next = {5'h0, tex_en_reg, 5'h0, ar_en_reg};
         REG_STATUS: rdata_next[ST_THERM:0] = {therm_reg == TH_STAGE_TWO, pump_low_flag,
                                               vs_ov_flag, vs_uv_flag, buf_uv_flag};
         REG_OC: rdata_next = {5'h0, ot_flag, 5'h0, oc_flag};
         REG_OL: rdata_next = {5'h0, alert_flag, 5'h0, ol_flag};
         REG_TEX: rdata_next = {14'h0, therm_reg, 5'h0, tex_flag};
         default: rd_hit = 1'b0;
      endcase
   end

   assign o_awready = awready_reg;
   assign o_wready = awready_reg;
   assign o_bvalid = bvalid_reg;
   assign o_bresp = bresp_reg;
   assign o_arready = arready_reg;
   assign o_rvalid = rvalid_reg;
   assign o_rresp = rresp_reg;
   assign o_rdata = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   buf_uv_set_a: assert property (@(posedge i_clock) disable iff (i_rst)
      buf_uv_s |=> buf_uv_flag) else $error("buffered undervoltage flag not set");
   buf_shutdown_a: assert property (@(posedge i_clock) disable iff (i_rst)
      buf_uv_flag && ctrl_reg[CTRL_BUF_SD] |=> !o_drive[BUF_CH] && o_can_enable)
      else $error("buffered output on during undervoltage");
   pump_gate_a: assert property (@(posedge i_clock) disable iff (i_rst)
      !pump_running |=> !o_drive[N_HB]) else $error("output on without charge pump");
   oc_latch_a: assert property (@(posedge i_clock) disable iff (i_rst)
      $rose(oc_flag[N_HB]) |=> !o_drive[N_HB] ##1 !o_drive[N_HB])
      else $error("driver on with overcurrent");
   pump_standby_a: assert property (@(posedge i_clock) disable iff (i_rst)
      standby_s [*2] |-> !o_pump_enable) else $error("pump enabled in standby");
   therm_resume_a: assert property (@(posedge i_clock) disable iff (i_rst)
      $fell(standby_s) && therm_saved_reg == TH_STAGE_TWO |=> therm_reg == TH_STAGE_ONE)
      else $error("thermal state not resumed as stage one");
   na_code_off_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (hs_mode[7:4] == 4'hb) ##1 (hs_mode[7:4] == 4'hb) |-> !o_drive[N_HB+1])
      else $error("unused mode code drove output");
   standby_pwm_a: assert property (@(posedge i_clock) disable iff (i_rst)
      (standby_s && g_ch[BUF_CH].is_pwm) [*2] |-> !o_drive[BUF_CH])
      else $error("buffered output driven by PWM in standby");
   part_write_a: assert property (@(posedge i_clock) disable iff (i_rst)
      wr_fire && !wr_full |=> $stable(ctrl_reg) && $stable(mode_reg))
      else $error("partial write committed");
endmodule : odp_ctrl
`default_nettype wire

// [hdl/odp_pkg.sv]
package odp_pkg;
   localparam int CLK_MHZ = 125;
   localparam int CNT_W = 20;
   localparam int PUMP_FILTER_NS = 30000;
   localparam int PUMP_FILTER_CYC = (PUMP_FILTER_NS * CLK_MHZ + 999) / 1000;
   localparam int OL_FILTER_NS = 20000;
   localparam int OL_FILTER_CYC = (OL_FILTER_NS * CLK_MHZ + 999) / 1000;
   localparam int AR_TIME_NS = 1000000;
   localparam int AR_TIME_CYC_DEF = (AR_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int AR_OFF_NS = 40000;
   localparam int AR_OFF_CYC_DEF = (AR_OFF_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] TEMP_RISE_LIMIT = 8'h1e;
   localparam int N_CH = 11;
   localparam int N_HB = 4;
   localparam int N_HS = 7;
   localparam int BUF_CH = 10;
   localparam logic [N_CH-1:0] AR_CAPABLE = 11'h43f;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_MODE = 8'h04;
   localparam logic [7:0] REG_HB = 8'h08;
   localparam logic [7:0] REG_AR = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_OC = 8'h14;
   localparam logic [7:0] REG_OL = 8'h18;
   localparam logic [7:0] REG_TEX = 8'h1c;
   // Control bits
   localparam int CTRL_BUF_SD = 0;
   localparam int CTRL_BUF_LOCK = 1;
   localparam int CTRL_MAIN_LOCK = 2;
   localparam int CTRL_UV_SD = 3;
   localparam int CTRL_OV_SD = 4;
   localparam int CTRL_PUMP_LIVE = 5;
   localparam logic [5:0] CTRL_RESET = 6'h19;
   localparam int HB_EC_BIT = 4;
   localparam int HI_FIELD = 16;
   // Status bits
   localparam int ST_BUF_UV = 0;
   localparam int ST_VS_UV = 1;
   localparam int ST_VS_OV = 2;
   localparam int ST_PUMP_LOW = 3;
   localparam int ST_THERM = 4;
   // Output mode codes
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_ON = 4'h1;
   localparam logic [3:0] MODE_TIMER1 = 4'h2;
   localparam logic [3:0] MODE_TIMER2 = 4'h3;
   localparam logic [3:0] MODE_PWM1 = 4'h4;
   localparam logic [3:0] MODE_PWM7 = 4'ha;
   localparam logic [3:0] MODE_DIR = 4'he;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {TH_NORMAL, TH_STAGE_ONE, TH_STAGE_TWO} odp_therm_e;
endpackage : odp_pkg

// [verification/odp_load_model.sv]
`timescale 1ns/10ps
`default_nettype none
module odp_load_model (
   input wire logic i_clock, // Bench clock
   output logic [1:0] o_timer, // Timer 1/2 outputs
   output logic [6:0] o_pwm, // PWM channels 1-7
   output logic [7:0] o_cluster_temp // Cluster temperature
);
   logic [3:0] phase_reg = 4'h0;
   always_ff @(posedge i_clock) begin
      phase_reg <= phase_reg + 4'h1;
   end
   // On phase comes first after every restart of the period
   assign o_timer = {2{~phase_reg[3]}};
   assign o_pwm = 7'h7f;
   assign o_cluster_temp = 8'h28;
endmodule : odp_load_model
`default_nettype wire

// [verification/tb_output_driver_protection_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_output_driver_protection_ctrl;
   import odp_pkg::*;
   logic clk = 0, rst = 1, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, awr, wr_rdy, bv, arr, rv;
   logic buf_uv = 0, vs_uv = 0, fs = 0, gl = 0, stby = 0, dir = 0, vs_ov = 0, pump_low = 0;
   logic [3:0] strb = 4'hf;
   logic [7:0] awa = 8'h0, ara = 8'h0, temp;
   logic [31:0] wd = 32'h0, rd, q;
   logic [1:0] br, rr, tmr, resp, bresp_seen;
   logic [6:0] pwm;
   logic [N_CH-1:0] oc = '0, lowc = '0, drv;
   logic hiz, can, pump, gpd, ec;
   int n_fail = 0, comparisons = 0;
   always #4 clk = ~clk;
   odp_load_model i_odp_load_model (.i_clock(clk), .o_timer(tmr), .o_pwm(pwm), .o_cluster_temp(temp));
   odp_ctrl #(.AR_TIME_CYC(20'h14), .AR_OFF_CYC(20'h4)) i_odp_ctrl (.i_clock(clk), .i_rst(rst),
      .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(strb),
      .i_wvalid(wv), .o_wready(wr_rdy), .o_bresp(br), .o_bvalid(bv), .i_bready(brdy),
      .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rd), .o_rresp(rr),
      .o_rvalid(rv), .i_rready(rrdy), .i_buf_uv(buf_uv), .i_vs_uv(vs_uv), .i_vs_ov(vs_ov),
      .i_failsafe(fs), .i_gnd_loss(gl), .i_pump_low(pump_low), .i_standby(stby), .i_thermal_stage_one(1'b0),
      .i_thermal_stage_two(1'b0), .i_direct(dir), .i_overcurrent(oc), .i_overtemp('0), .i_low_current(lowc),
      .i_timer(tmr), .i_pwm(pwm), .i_cluster_temp(temp), .o_drive(drv), .o_lin_tx_hiz(hiz),
      .o_can_enable(can), .o_pump_enable(pump), .o_gate_pulldown(gpd), .o_ec_enable(ec));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %0t got %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {awa, wd, awv, wv, brdy} <= {a, d, 3'b111};
      do @(posedge clk); while (awr !== 1'b1 || wr_rdy !== 1'b1);
      {awv, wv} <= 2'b00;
      do @(posedge clk); while (bv !== 1'b1);
      bresp_seen = br;
      brdy <= 1'b0;
   endtask : wr
   task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      {ara, arv, rrdy} <= {a, 2'b11};
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk); while (rv !== 1'b1);
      d = rd;
      r = rr;
      rrdy <= 1'b0;
   endtask : rdw
   task automatic settle();
      repeat (8) @(posedge clk);
   endtask : settle
   task automatic print_verdict();
      if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   task automatic t_reset_map();
      rdw(REG_CTRL, q, resp);
      chk(q, 32'h19);
      rdw(8'h40, q, resp);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR});
      wr(8'h40, 32'h0);
      chk({30'h0, bresp_seen}, {30'h0, RESP_SLVERR});
      strb <= 4'h3;
      wr(REG_CTRL, 32'h0);
      strb <= 4'hf;
      rdw(REG_CTRL, q, resp);
      chk(q, 32'h19);
   endtask : t_reset_map
   task automatic t_modes();
      dir <= 1'b1;
      wr(REG_MODE, 32'h0100_0eb1);
      settle();
      chk(drv[10:4], 7'h45);
      stby <= 1'b1;
      settle();
      chk({pump, drv[10], drv[4]}, 3'b010);
      wr(REG_MODE, 32'h0400_0eb1);
      settle();
      chk(drv[10], 1'b0);
      stby <= 1'b0;
      settle();
      chk(drv[10], 1'b1);
      wr(REG_MODE, 32'h0100_0eb1);
      settle();
   endtask : t_modes
   task automatic t_buf_uv();
      wr(REG_CTRL, 32'h1b);
      buf_uv <= 1'b1;
      settle();
      chk({hiz, can, drv[10]}, 3'b110);
      buf_uv <= 1'b0;
      settle();
      rdw(REG_STATUS, q, resp);
      chk({q[0], drv[10]}, 2'b10);
      wr(REG_STATUS, 32'h1);
      settle();
      chk(drv[10], 1'b1);
   endtask : t_buf_uv
   task automatic t_oc_ol();
      oc[4] <= 1'b1;
      settle();
      oc[4] <= 1'b0;
      settle();
      rdw(REG_OC, q, resp);
      chk({q[4], drv[4]}, 2'b10);
      wr(REG_OC, 32'h10);
      lowc[4] <= 1'b1;
      repeat (OL_FILTER_CYC + 8) @(posedge clk);
      rdw(REG_OL, q, resp);
      chk({q[4], drv[4]}, 2'b11);
      lowc[4] <= 1'b0;
   endtask : t_oc_ol
   task automatic t_pump();
      wr(REG_HB, 32'h10);
      vs_ov <= 1'b1;
      settle();
      chk({pump, drv[4]}, 2'b00);
      vs_ov <= 1'b0;
      settle();
      chk({pump, drv[4], ec}, 3'b111);
      pump_low <= 1'b1;
      repeat (PUMP_FILTER_CYC + 16) @(posedge clk);
      chk({gpd, drv[4], ec}, 3'b100);
      pump_low <= 1'b0;
      settle();
      chk(gpd, 1'b1);
      wr(REG_STATUS, 32'h8);
      settle();
      chk({gpd, drv[4], ec}, 3'b011);
   endtask : t_pump
   task automatic t_faults();
      for (int k = 0; k < 3; k++) begin
         {vs_uv, fs, gl} <= 3'b100 >> k;
         settle();
         chk(drv, (k == 0) ? 11'h400 : 11'h0);
         {vs_uv, fs, gl} <= 3'b000;
         settle();
      end
   endtask : t_faults
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      t_reset_map();
      t_modes();
      t_buf_uv();
      t_oc_ol();
      t_pump();
      t_faults();
      print_verdict();
   end
   initial begin
      #100000;
      n_fail++;
      print_verdict();
   end
endmodule : tb_output_driver_protection_ctrl
`default_nettype wire
